// *** slr_pkg.sv ***
package slr_pkg;
    localparam int LANES_DFLT    = 2;
    localparam int LANE_W        = 32;
    localparam int PHY_W_FULL    = 32;
    localparam int PHY_W_LOW     = 16;
    localparam int WDOG_BITS     = 20;
    localparam int MGMT_DIV      = 1;
    localparam int CORE_CLK_MHZ  = 125;
    localparam int XCVR_HOLD_NS  = 128;
    localparam int XCVR_HOLD_CYC = (XCVR_HOLD_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int DP_HOLD_NS    = 256;
    localparam int DP_HOLD_CYC   = (DP_HOLD_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int CNT_W         = 16;
    localparam logic WDOG_EN_RST = 1'b1;
    localparam int FMT_14B_2L    = 0;
    localparam int FMT_16B_PAIR  = 1;
    localparam int SAMPLE_W      = 16;
    typedef enum logic [2:0] {
        ST_XRST = 3'b001,
        ST_DRST = 3'b010,
        ST_RUN  = 3'b100
    } slr_state_t;
endpackage : slr_pkg

// *** slr_if.sv ***
`timescale 1ns/100ps
interface slr_if #(parameter int LANES = slr_pkg::LANES_DFLT);
    logic [LANES*slr_pkg::LANE_W-1:0] rx_tdata;
    logic                             rx_tvalid;
    logic                             rx_aresetn;
    logic [LANES*slr_pkg::LANE_W-1:0] tx_tdata;
    logic                             tx_tready;
    logic                             tx_aresetn;
    modport dev (
        output rx_tdata,
        output rx_tvalid,
        output rx_aresetn,
        input  tx_tdata,
        output tx_tready,
        output tx_aresetn
    );
    modport usr (
        input  rx_tdata,
        input  rx_tvalid,
        input  rx_aresetn,
        output tx_tdata,
        input  tx_tready,
        input  tx_aresetn
    );
endinterface : slr_if

// *** slr_core.sv ***
`timescale 1ns/100ps
module slr_core #(
    parameter int LANES     = slr_pkg::LANES_DFLT,
    parameter int PHY_W     = slr_pkg::PHY_W_FULL,
    parameter int WDOG_BITS = slr_pkg::WDOG_BITS,
    parameter int MGMT_DIV  = slr_pkg::MGMT_DIV
) (
    input  wire logic                   CORE_CLK,
    input  wire logic                   RESET_N,
    input  wire logic                   SYS_RST,
    input  wire logic                   CFG_WR,
    input  wire logic                   CFG_WDOG_EN,
    input  wire logic                   CFG_SW_RST,
    input  wire logic                   LINK_SYNC,
    input  wire logic [LANES*PHY_W-1:0] PHY_RX_DATA,
    input  wire logic                   PHY_RX_VALID,
    output logic      [LANES*PHY_W-1:0] PHY_TX_DATA,
    output logic                        XCVR_RST,
    output logic                        PHY_DP_RST,
    output logic                        WDOG_EN,
    output logic                        WDOG_FIRED,
    slr_if.dev                          link
);
    localparam int DW = LANES * slr_pkg::LANE_W;
    localparam int HW = slr_pkg::PHY_W_LOW;

    slr_pkg::slr_state_t          st_q;
    slr_pkg::slr_state_t          st_d;
    logic [slr_pkg::CNT_W-1:0]    cnt_q;
    logic [slr_pkg::CNT_W-1:0]    div_q;
    logic                         tick_q;
    logic [WDOG_BITS-1:0]         wdog_q;
    logic                         wdog_en_q;
    logic                         sw_hit;
    logic                         wdog_fire;
    logic                         restart;

    // pick low or high 16-bit half of every lane
    function automatic logic [LANES*HW-1:0] half_of(input logic [DW-1:0] w,
                                                    input logic          hi);
        logic [LANES*HW-1:0] r;
        r = '0;
        for (int l = 0; l < LANES; l++) begin
            r[l*HW +: HW] = w[l*slr_pkg::LANE_W + (hi ? HW : 0) +: HW];
        end
        return r;
    endfunction : half_of

    assign sw_hit    = CFG_WR && CFG_SW_RST;
    assign wdog_fire = tick_q && (&wdog_q) && wdog_en_q && !LINK_SYNC
                       && (st_q == slr_pkg::ST_RUN);
    assign restart   = (st_q == slr_pkg::ST_DRST) && (sw_hit || wdog_fire);

    always_comb begin
        st_d = st_q;
        case (st_q)
            slr_pkg::ST_XRST: begin
                if (cnt_q == slr_pkg::CNT_W'(slr_pkg::XCVR_HOLD_CYC - 1)) begin
                    st_d = slr_pkg::ST_DRST;
                end
            end
            slr_pkg::ST_DRST: begin
                if (cnt_q == slr_pkg::CNT_W'(slr_pkg::DP_HOLD_CYC - 1) && !restart) begin
                    st_d = slr_pkg::ST_RUN;
                end
            end
            slr_pkg::ST_RUN: begin
                if (sw_hit || wdog_fire) begin
                    st_d = slr_pkg::ST_DRST;
                end
            end
            default: st_d = slr_pkg::ST_XRST;
        endcase
        if (SYS_RST) begin
            st_d = slr_pkg::ST_XRST;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            st_q <= slr_pkg::ST_XRST;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || SYS_RST || st_d != st_q || restart) begin
            cnt_q <= '0;
        end else if (st_q != slr_pkg::ST_RUN) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // only the management reset touches configuration
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            wdog_en_q <= slr_pkg::WDOG_EN_RST;
        end else if (CFG_WR) begin
            wdog_en_q <= CFG_WDOG_EN;
        end
    end

    // management clock rate as an enable pulse
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == slr_pkg::CNT_W'(MGMT_DIV - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // counts only continuous loss of sync in the running state
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            wdog_q <= '0;
        end else if (LINK_SYNC || !wdog_en_q || st_q != slr_pkg::ST_RUN || wdog_fire) begin
            wdog_q <= '0;
        end else if (tick_q) begin
            wdog_q <= wdog_q + 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            XCVR_RST        <= 1'b1;
            PHY_DP_RST      <= 1'b1;
            link.rx_aresetn <= 1'b0;
            link.tx_aresetn <= 1'b0;
            WDOG_EN         <= slr_pkg::WDOG_EN_RST;
            WDOG_FIRED      <= 1'b0;
        end else begin
            XCVR_RST        <= (st_d == slr_pkg::ST_XRST);
            PHY_DP_RST      <= (st_d != slr_pkg::ST_RUN);
            link.rx_aresetn <= (st_d == slr_pkg::ST_RUN);
            link.tx_aresetn <= (st_d == slr_pkg::ST_RUN);
            WDOG_EN         <= wdog_en_q;
            WDOG_FIRED      <= wdog_fire;
        end
    end

    generate
        if (PHY_W == slr_pkg::PHY_W_FULL) begin : g_full
            always_ff @(posedge CORE_CLK) begin
                if (!RESET_N || st_d != slr_pkg::ST_RUN) begin
                    link.rx_tdata  <= '0;
                    link.rx_tvalid <= 1'b0;
                    link.tx_tready <= 1'b0;
                    PHY_TX_DATA    <= '0;
                end else begin
                    link.rx_tdata  <= PHY_RX_DATA;
                    link.rx_tvalid <= PHY_RX_VALID;
                    link.tx_tready <= 1'b1;
                    PHY_TX_DATA    <= link.tx_tdata;
                end
            end
        end else begin : g_low
            // two half words per stream word, earlier half in low bytes
            logic [LANES*HW-1:0] rx_lo_q;
            logic                rx_half_q;
            logic [LANES*HW-1:0] tx_hi_q;
            always_ff @(posedge CORE_CLK) begin
                if (!RESET_N || st_d != slr_pkg::ST_RUN) begin
                    rx_lo_q        <= '0;
                    rx_half_q      <= 1'b0;
                    link.rx_tdata  <= '0;
                    link.rx_tvalid <= 1'b0;
                end else begin
                    link.rx_tvalid <= PHY_RX_VALID && rx_half_q;
                    if (PHY_RX_VALID) begin
                        rx_half_q <= !rx_half_q;
                        if (!rx_half_q) begin
                            rx_lo_q <= PHY_RX_DATA;
                        end else begin
                            for (int l = 0; l < LANES; l++) begin
                                link.rx_tdata[l*slr_pkg::LANE_W +: slr_pkg::LANE_W]
                                    <= {PHY_RX_DATA[l*HW +: HW], rx_lo_q[l*HW +: HW]};
                            end
                        end
                    end
                end
            end
            always_ff @(posedge CORE_CLK) begin
                if (!RESET_N || st_d != slr_pkg::ST_RUN) begin
                    tx_hi_q        <= '0;
                    link.tx_tready <= 1'b0;
                    PHY_TX_DATA    <= '0;
                end else begin
                    link.tx_tready <= !link.tx_tready;
                    if (link.tx_tready) begin
                        PHY_TX_DATA <= half_of(link.tx_tdata, 1'b0);
                        tx_hi_q     <= half_of(link.tx_tdata, 1'b1);
                    end else begin
                        PHY_TX_DATA <= tx_hi_q;
                    end
                end
            end
        end
    endgenerate
endmodule : slr_core

// *** slr_user.sv ***
`timescale 1ns/100ps
module slr_user #(
    parameter int LANES = slr_pkg::LANES_DFLT,
    parameter int FMT   = slr_pkg::FMT_14B_2L
) (
    input  wire logic                                 CORE_CLK,
    input  wire logic                                 RESET_N,
    input  wire logic [LANES*slr_pkg::LANE_W-1:0]     TX_DATA,
    output logic      [LANES*2*slr_pkg::SAMPLE_W-1:0] SAMPLE_DATA,
    output logic                                      SAMPLE_VALID,
    slr_if.usr                                        link
);
    localparam int NS = LANES * 2;
    localparam int LW = slr_pkg::LANE_W;
    localparam int SW = slr_pkg::SAMPLE_W;

    // stream reset from the core gates both directions
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || !link.rx_aresetn) begin
            SAMPLE_DATA  <= '0;
            SAMPLE_VALID <= 1'b0;
        end else begin
            SAMPLE_VALID <= link.rx_tvalid;
            for (int k = 0; k < NS; k++) begin
                if (FMT == slr_pkg::FMT_14B_2L) begin
                    SAMPLE_DATA[k*SW +: SW] <= {2'b00,
                        link.rx_tdata[(k/2)*LW + (k%2)*16 +: 8],
                        link.rx_tdata[(k/2)*LW + (k%2)*16 + 10 +: 6]};
                end else begin
                    SAMPLE_DATA[k*SW +: SW] <= {
                        link.rx_tdata[(2*(k/4))*LW + (k%4)*8 +: 8],
                        link.rx_tdata[(2*(k/4)+1)*LW + (k%4)*8 +: 8]};
                end
            end
        end
    end

    // word is held until the core takes it
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || !link.tx_aresetn) begin
            link.tx_tdata <= '0;
        end else if (link.tx_tready || !link.tx_aresetn) begin
            link.tx_tdata <= TX_DATA;
        end
    end
endmodule : slr_user

// *** slr_asserts.sv ***
`timescale 1ns/100ps
module slr_asserts #(
    parameter int LANES     = slr_pkg::LANES_DFLT,
    parameter int WDOG_BITS = slr_pkg::WDOG_BITS
) (
    input wire logic                   CORE_CLK,
    input wire logic                   RESET_N,
    input wire logic                   SYS_RST,
    input wire logic                   CFG_WR,
    input wire logic                   CFG_WDOG_EN,
    input wire logic                   CFG_SW_RST,
    input wire logic                   LINK_SYNC,
    input wire logic                   PHY_RX_VALID,
    input wire logic [LANES*32-1:0]    PHY_RX_DATA,
    input wire logic                   XCVR_RST,
    input wire logic                   PHY_DP_RST,
    input wire logic                   WDOG_EN,
    input wire logic                   WDOG_FIRED,
    input wire logic [LANES*32-1:0]    rx_tdata,
    input wire logic                   rx_tvalid,
    input wire logic                   rx_aresetn,
    input wire logic                   tx_aresetn
);
    localparam int WMIN = 2 ** WDOG_BITS;
    logic [23:0] lost_q;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // lower bound only: design counts in run state alone
    always_ff @(posedge CORE_CLK) begin
        if (!RESET_N || LINK_SYNC || WDOG_FIRED) begin
            lost_q <= 24'h00_0000;
        end else begin
            lost_q <= lost_q + 24'h00_0001;
        end
    end
    sequence sw_wr_s;
        CFG_WR && CFG_SW_RST && rx_aresetn;
    endsequence
    sequence dp_hold_s;
        !rx_aresetn ##30 !rx_aresetn;
    endsequence
    rst_defaults_a: assert property (disable iff (1'b0)
        !RESET_N |=> WDOG_EN && XCVR_RST && !rx_aresetn) else $error("reset state wrong");
    sw_seq_a: assert property (sw_wr_s |-> ##2 dp_hold_s)
        else $error("soft reset hold wrong");
    xcvr_cause_a: assert property ($rose(XCVR_RST) |-> $past(SYS_RST))
        else $error("transceiver reset without cause");
    dp_tie_a: assert property (PHY_DP_RST |-> !rx_aresetn && !tx_aresetn)
        else $error("stream reset released early");
    fire_reset_a: assert property (WDOG_FIRED |-> ##[1:2] PHY_DP_RST)
        else $error("expiry without datapath reset");
    fire_min_a: assert property (WDOG_FIRED |-> lost_q >= WMIN)
        else $error("watchdog fired early");
    en_write_a: assert property (CFG_WR |-> ##3 WDOG_EN == $past(CFG_WDOG_EN, 3))
        else $error("enable write lost");
    rx_map_a: assert property (PHY_RX_VALID && rx_aresetn ##1 rx_aresetn |->
        rx_tvalid && rx_tdata == $past(PHY_RX_DATA)) else $error("rx word wrong");
endmodule : slr_asserts

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
    localparam int LN = 2;
    localparam int WB = 3;
    logic        core_clk, reset_n, sys_rst, cfg_wr, cfg_wdog_en, cfg_sw_rst, link_sync;
    logic        phy_rx_valid, xcvr_rst, phy_dp_rst, wdog_en, wdog_fired, sample_valid;
    logic [63:0] phy_rx_data, phy_tx_data, tx_data, sample_data;
    logic [31:0] phy_lo_rx, phy_lo_tx, lo_a;
    logic [63:0] sample_lo;
    logic        sample_valid_lo;
    int          fail_count, tests_run, cyc, fires;
    slr_if #(.LANES(LN)) link ();
    slr_if #(.LANES(LN)) link_lo ();
    // second pair exercises the half-width datapath and the paired-lane format
    slr_core #(.LANES(LN), .PHY_W(slr_pkg::PHY_W_LOW), .WDOG_BITS(WB)) u_slr_core_lo (
        .CORE_CLK(core_clk), .RESET_N(reset_n),
        .SYS_RST(sys_rst), .CFG_WR(cfg_wr), .CFG_WDOG_EN(cfg_wdog_en), .CFG_SW_RST(cfg_sw_rst),
        .LINK_SYNC(link_sync), .PHY_RX_DATA(phy_lo_rx), .PHY_RX_VALID(phy_rx_valid),
        .PHY_TX_DATA(phy_lo_tx), .XCVR_RST(), .PHY_DP_RST(),
        .WDOG_EN(), .WDOG_FIRED(), .link(link_lo));
    slr_user #(.LANES(LN), .FMT(slr_pkg::FMT_16B_PAIR)) u_slr_user_lo (.CORE_CLK(core_clk),
        .RESET_N(reset_n), .TX_DATA(tx_data), .SAMPLE_DATA(sample_lo),
        .SAMPLE_VALID(sample_valid_lo), .link(link_lo));
    slr_core #(.LANES(LN), .WDOG_BITS(WB)) u_slr_core (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .SYS_RST(sys_rst), .CFG_WR(cfg_wr), .CFG_WDOG_EN(cfg_wdog_en), .CFG_SW_RST(cfg_sw_rst),
        .LINK_SYNC(link_sync), .PHY_RX_DATA(phy_rx_data), .PHY_RX_VALID(phy_rx_valid),
        .PHY_TX_DATA(phy_tx_data), .XCVR_RST(xcvr_rst), .PHY_DP_RST(phy_dp_rst),
        .WDOG_EN(wdog_en), .WDOG_FIRED(wdog_fired), .link(link));
    slr_user #(.LANES(LN)) u_slr_user (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .TX_DATA(tx_data), .SAMPLE_DATA(sample_data), .SAMPLE_VALID(sample_valid), .link(link));
    slr_asserts #(.LANES(LN), .WDOG_BITS(WB)) u_slr_asserts (.CORE_CLK(core_clk),
        .RESET_N(reset_n), .SYS_RST(sys_rst), .CFG_WR(cfg_wr), .CFG_WDOG_EN(cfg_wdog_en),
        .CFG_SW_RST(cfg_sw_rst), .LINK_SYNC(link_sync), .PHY_RX_VALID(phy_rx_valid),
        .PHY_RX_DATA(phy_rx_data), .XCVR_RST(xcvr_rst), .PHY_DP_RST(phy_dp_rst),
        .WDOG_EN(wdog_en), .WDOG_FIRED(wdog_fired), .rx_tdata(link.rx_tdata),
        .rx_tvalid(link.rx_tvalid), .rx_aresetn(link.rx_aresetn), .tx_aresetn(link.tx_aresetn));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // whole run needs well under 400 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (wdog_fired === 1'b1) fires++;
        if (cyc == 3000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic cfg(input logic en, input logic sw);
        cfg_wr = 1'b1;
        cfg_wdog_en = en;
        cfg_sw_rst = sw;
        step(1);
        cfg_wr = 1'b0;
        cfg_sw_rst = 1'b0;
    endtask : cfg
    task automatic wait_run;
        int n;
        n = 0;
        while (link.rx_aresetn !== 1'b1 && n < 80) begin
            step(1);
            n++;
        end
        chk(64'(n < 80), 64'h1);
    endtask : wait_run
    function automatic logic [63:0] samp(input logic [63:0] d);
        logic [63:0] s;
        int i;
        s = '0;
        for (int k = 0; k < 4; k++) begin
            i = (k / 2) * 4 + (k % 2) * 2;
            s[16*k+:16] = {2'h0, d[8*i+:8], d[8*i+10+:6]};
        end
        return s;
    endfunction : samp
    initial begin
        reset_n = 1'b0;
        sys_rst = 1'b0;
        cfg_wr = 1'b0;
        cfg_wdog_en = 1'b0;
        cfg_sw_rst = 1'b0;
        link_sync = 1'b1;
        phy_rx_valid = 1'b0;
        phy_rx_data = '0;
        phy_lo_rx = '0;
        tx_data = '0;
        step(6);
        reset_n = 1'b1;
        wait_run();
        chk(64'(wdog_en), 64'h1);
        phy_rx_data = 64'h1234_5678_9abc_def0;
        phy_lo_rx = 32'h5678_def0;
        phy_rx_valid = 1'b1;
        tx_data = 64'hcafe_0123_4567_89ab;
        step(1);
        phy_lo_rx = 32'h1234_9abc;
        step(1);
        chk(link_lo.rx_tdata, 64'h1234_5678_9abc_def0);
        chk(link.rx_tdata, 64'h1234_5678_9abc_def0);
        chk(sample_data, samp(64'h1234_5678_9abc_def0));
        chk(phy_tx_data, 64'hcafe_0123_4567_89ab);
        chk(64'(sample_valid), 64'h1);
        step(1);
        chk(sample_lo, 64'h9a12_bc34_de56_f078);
        chk(64'(sample_valid_lo), 64'h1);
        // tx phase of the half-width toggle is not pinned, so either order
        step(2);
        lo_a = phy_lo_tx;
        step(1);
        chk(64'((lo_a == 32'h0123_89ab && phy_lo_tx == 32'hcafe_4567) ||
                (lo_a == 32'hcafe_4567 && phy_lo_tx == 32'h0123_89ab)), 64'h1);
        cfg(1'b1, 1'b1);
        step(1);
        chk({link.rx_aresetn, link.tx_aresetn, xcvr_rst, phy_dp_rst}, 64'h1);
        wait_run();
        chk(64'(wdog_en), 64'h1);
        cfg(1'b0, 1'b0);
        link_sync = 1'b0;
        step(30);
        chk({fires, wdog_en, link.rx_aresetn}, 64'h1);
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        chk({xcvr_rst, wdog_en}, 64'h2);
        wait_run();
        cfg(1'b1, 1'b0);
        step(16);
        chk({fires, link.rx_aresetn}, 64'h2);
        link_sync = 1'b1;
        wait_run();
        step(20);
        chk(64'(fires), 64'h1);
        cfg(1'b0, 1'b0);
        step(3);
        reset_n = 1'b0;
        step(2);
        chk({xcvr_rst, wdog_en, link.rx_aresetn}, 64'h6);
        reset_n = 1'b1;
        wait_run();
        report_and_stop();
    end
endmodule : testbench
